/* rtl/sgt_map.svh */
// register map, field positions, reset values and widths of the status, port and threshold bank
`ifndef SGT_MAP_SVH
`define SGT_MAP_SVH

// ------------------------------------------------------------------
// widths and channel slots
// ------------------------------------------------------------------
`define SGT_RES_W 12
`define SGT_N_CH 6
`define SGT_N_ADC 5
`define SGT_LT_IDX 3'd5
`define SGT_PORT_W 8

// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define SGT_ADDR_ALARM0 8'h70
`define SGT_ADDR_ALARM1 8'h71
`define SGT_ADDR_STATUS 8'h72
`define SGT_ADDR_PORT 8'h7a
`define SGT_ADDR_THR_BASE 8'h80
`define SGT_ADDR_THR_LAST 8'h97

// byte slot inside one channel's four-byte threshold group
`define SGT_SLOT_UPPER_LO 2'd0
`define SGT_SLOT_UPPER_HI 2'd1
`define SGT_SLOT_LOWER_LO 2'd2
`define SGT_SLOT_LOWER_HI 2'd3

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define SGT_RST_STATUS 8'h0c
`define SGT_RST_PORT 8'hff
`define SGT_RST_ADC_UPPER 12'hfff
`define SGT_RST_ADC_LOWER 12'h000
`define SGT_RST_LT_UPPER 12'h7ff
`define SGT_RST_LT_LOWER 12'h800
`define SGT_STATUS_RSVD 1'b1
`define SGT_READ_ZERO 8'h00

`endif

/* rtl/sgt_pkg.sv */
// types shared by the status, port and threshold bank
package sgt_pkg;

    // ------------------------------------------------------------------
    // register request from the serial front end, same clock
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } sgt_reg_req_t;

    // converter sequencer indications, same clock
    typedef struct packed {
        logic auto_mode;
        logic start;
        logic stop;
        logic direct_done;
    } sgt_conv_ctl_t;

    // one result strobe per slot; slot 5 is the temperature sensor
    typedef struct packed {
        logic [5:0] valid;
        logic [5:0][11:0] data;
    } sgt_results_t;

    // general status layout, bit 7 down to bit 0
    typedef struct packed {
        logic [3:0] range;
        logic idle;
        logic rsvd;
        logic global_alarm;
        logic data_available_flag;
    } sgt_status_t;

    // converter activity; gray along idle -> auto and idle -> direct
    typedef enum logic [1:0] {
        SGT_IDLE = 2'b00,
        SGT_AUTO = 2'b01,
        SGT_DIRECT = 2'b10
    } sgt_conv_state_t;

endpackage

/* rtl/sgt_sync.sv */
// two-stage level synchroniser for pins entering the device clock
`timescale 1ns/1ps
module sgt_sync
    import sgt_pkg::*;
#(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // asynchronous levels and their synchronised copy
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);

    logic [W-1:0] meta_q;

    // ------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------
    if (W < 1) begin : g_bad_w
        $error("sgt_sync: width must be at least one");
    end

    // first stage is read by the second stage only
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

/* rtl/sgt_window_cmp.sv */
// window comparator for one monitored channel, straight binary or two's complement
`timescale 1ns/1ps
module sgt_window_cmp
    import sgt_pkg::*;
#(
    parameter int W = 12
) (
    // format select: high for two's complement bounds and result
    input wire logic signed_i,
    // result and bounds
    input wire logic [W-1:0] result_i,
    input wire logic [W-1:0] upper_i,
    input wire logic [W-1:0] lower_i,
    // outside the window, or bounds not ordered
    output logic alarm_o
);

    // ------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------
    if (W < 2) begin : g_bad_w
        $error("sgt_window_cmp: width must be at least two");
    end

    // flipping the sign bit maps two's complement order onto unsigned order
    function automatic logic [W-1:0] to_order(input logic [W-1:0] v, input logic s);
        to_order = {v[W-1] ^ s, v[W-2:0]};
    endfunction

    logic [W-1:0] res_o;
    logic [W-1:0] up_o;
    logic [W-1:0] lo_o;

    // comparison in a common unsigned order
    always_comb begin
        res_o = to_order(result_i, signed_i);
        up_o = to_order(upper_i, signed_i);
        lo_o = to_order(lower_i, signed_i);
        // unordered bounds alarm regardless of the result
        alarm_o = (up_o <= lo_o) || (res_o > up_o) || (res_o < lo_o);
    end

endmodule

/* rtl/sgt_regs.sv */
// general status, open-drain port and window alarm register bank
// Operation
// - four range flags, bits 7..4, read 1 when group supply is below threshold.
// - auto mode: idle bit drops on trigger, returns to 1 only when stopped.
// - direct mode: idle drops when conversions begin, returns when they complete.
// - global alarm is the OR of every individual alarm flag.
// - global alarm stays set until the status register is read, then clears.
// - data-available flag is held at 0 while auto mode is selected.
// - direct mode: data-available reads 1 when done, 0 while converting.
// - status at 0x72 is read-only, resets to 0x0C.
// - writing 1 to a port bit releases that pin.
// - writing 0 to a port bit drives that pin low.
// - reading the port returns sampled pin levels, not written values.
// - port at 0x7A is read/write, resets to 0xFF, all pins released.
// - only five unipolar inputs and the temperature sensor get window alarms.
// - a result outside its window sets that channel's alarm flag.
// - upper bound not above lower bound means permanent alarm.
// - analog bounds are unsigned, temperature bounds two's complement.
// - analog upper bound low byte is read/write, resets 0xFF, inside 0x80..0x93.
// - upper bound top nibble sits in a high byte resetting to 0x0F.
// - alarm flag reads 1 while outside, 0 inside; channel 20 at bit 4.
`timescale 1ns/1ps
`include "sgt_map.svh"
module sgt_regs
    import sgt_pkg::*;
#(
    parameter int PORT_W = `SGT_PORT_W
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // register access from the serial front end
    input wire sgt_reg_req_t reg_req_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // converter sequencer and results
    input wire sgt_conv_ctl_t conv_ctl_i,
    input wire sgt_results_t results_i,
    // supply range detectors, asynchronous
    input wire logic [3:0] range_det_i,
    // open-drain port pins
    input wire logic [PORT_W-1:0] port_pin_i,
    output logic [PORT_W-1:0] port_pin_o,
    output logic [PORT_W-1:0] port_pin_oe_o
);

    // ------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------
    if (PORT_W < 1 || PORT_W > `SGT_PORT_W) begin : g_bad_port
        $error("sgt_regs: port width must be one to eight");
    end

    localparam int RW = `SGT_RES_W;
    localparam int NC = `SGT_N_CH;

    // ------------------------------------------------------------------
    // address helpers
    // ------------------------------------------------------------------
    function automatic logic thr_hit(input logic [7:0] a);
        thr_hit = (a >= `SGT_ADDR_THR_BASE) && (a <= `SGT_ADDR_THR_LAST);
    endfunction

    function automatic logic [4:0] thr_off(input logic [7:0] a);
        logic [7:0] d;
        d = a - `SGT_ADDR_THR_BASE;
        thr_off = d[4:0];
    endfunction

    logic wr_thr;
    logic rd_status;
    logic [4:0] woff;
    logic [2:0] wch;

    assign wr_thr = reg_req_i.wr && thr_hit(reg_req_i.addr);
    assign rd_status = reg_req_i.rd && (reg_req_i.addr == `SGT_ADDR_STATUS);
    assign woff = thr_off(reg_req_i.addr);
    assign wch = woff[4:2];

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    logic [3:0] range_s;
    logic [PORT_W-1:0] port_s;

    sgt_sync #(.W(4)) u_range_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .async_i(range_det_i),
        .sync_o(range_s)
    );

    sgt_sync #(.W(PORT_W)) u_port_sync (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .async_i(port_pin_i),
        .sync_o(port_s)
    );

    // ------------------------------------------------------------------
    // open-drain port
    // ------------------------------------------------------------------
    // the enable register is the port state itself; reads show the pins, so no shadow copy is kept

    // a written 1 releases the pin, a 0 pulls it low; nothing ever drives high
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            port_pin_oe_o <= ~PORT_W'(`SGT_RST_PORT);
            port_pin_o <= '0;
        end else begin
            port_pin_o <= '0;
            if (reg_req_i.wr && reg_req_i.addr == `SGT_ADDR_PORT) begin
                port_pin_oe_o <= ~reg_req_i.wdata[PORT_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // threshold storage, four bytes per slot, slot 5 is temperature
    // ------------------------------------------------------------------
    logic [RW-1:0] upper_q [NC];
    logic [RW-1:0] lower_q [NC];

    // only the low nibble of a high byte is stored; its reserved bits read zero
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < NC; i++) begin
                upper_q[i] <= (i == NC - 1) ? `SGT_RST_LT_UPPER : `SGT_RST_ADC_UPPER;
                lower_q[i] <= (i == NC - 1) ? `SGT_RST_LT_LOWER : `SGT_RST_ADC_LOWER;
            end
        end else if (wr_thr) begin
            case (woff[1:0])
                `SGT_SLOT_UPPER_LO: begin
                    upper_q[wch][7:0] <= reg_req_i.wdata;
                end
                `SGT_SLOT_UPPER_HI: begin
                    upper_q[wch][RW-1:8] <= reg_req_i.wdata[3:0];
                end
                `SGT_SLOT_LOWER_LO: begin
                    lower_q[wch][7:0] <= reg_req_i.wdata;
                end
                `SGT_SLOT_LOWER_HI: begin
                    lower_q[wch][RW-1:8] <= reg_req_i.wdata[3:0];
                end
                default: begin
                    upper_q[wch] <= upper_q[wch];
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // latched results and window comparison
    // ------------------------------------------------------------------
    logic [RW-1:0] res_q [NC];
    logic [NC-1:0] alarm_w;
    logic [NC-1:0] alarm_q;

    // results start at zero, which lies inside every reset window
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            for (int i = 0; i < NC; i++) begin
                res_q[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NC; i++) begin
                if (results_i.valid[i]) begin
                    res_q[i] <= results_i.data[i];
                end
            end
        end
    end

    // one comparator per monitored slot and none for the bipolar inputs
    for (genvar g = 0; g < NC; g++) begin : g_cmp
        sgt_window_cmp #(.W(RW)) u_cmp (
            .signed_i(g == NC - 1),
            .result_i(res_q[g]),
            .upper_i(upper_q[g]),
            .lower_i(lower_q[g]),
            .alarm_o(alarm_w[g])
        );
    end

    // flags are live: they follow the window, they do not latch
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            alarm_q <= '0;
        end else begin
            alarm_q <= alarm_w;
        end
    end

    // ------------------------------------------------------------------
    // converter activity and data-available
    // ------------------------------------------------------------------
    sgt_conv_state_t state_q;
    logic data_available_flag_q;
    logic global_alarm_q;

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state_q <= SGT_IDLE;
        end else begin
            case (state_q)
                SGT_IDLE: begin
                    if (conv_ctl_i.start) begin
                        state_q <= conv_ctl_i.auto_mode ? SGT_AUTO : SGT_DIRECT;
                    end
                end
                SGT_AUTO: begin
                    if (conv_ctl_i.stop) begin
                        state_q <= SGT_IDLE;
                    end
                end
                SGT_DIRECT: begin
                    if (conv_ctl_i.direct_done) begin
                        state_q <= SGT_IDLE;
                    end
                end
                default: begin
                    state_q <= SGT_IDLE;
                end
            endcase
        end
    end

    // auto mode forces zero; in direct mode completion wins over a new start
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            data_available_flag_q <= 1'b0;
        end else if (conv_ctl_i.auto_mode) begin
            data_available_flag_q <= 1'b0;
        end else if (state_q == SGT_DIRECT && conv_ctl_i.direct_done) begin
            data_available_flag_q <= 1'b1;
        end else if (conv_ctl_i.start) begin
            data_available_flag_q <= 1'b0;
        end
    end

    // an alarm present in the read cycle sets again, so no event is lost
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            global_alarm_q <= 1'b0;
        end else if (|alarm_q) begin
            global_alarm_q <= 1'b1;
        end else if (rd_status) begin
            global_alarm_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // read path, one cycle after the request
    // ------------------------------------------------------------------
    sgt_status_t status_w;
    logic [7:0] rd_w;

    always_comb begin
        status_w.range = range_s;
        status_w.idle = (state_q == SGT_IDLE);
        status_w.rsvd = `SGT_STATUS_RSVD;
        status_w.global_alarm = global_alarm_q;
        status_w.data_available_flag = data_available_flag_q;
        rd_w = `SGT_READ_ZERO;
        if (thr_hit(reg_req_i.addr)) begin
            case (woff[1:0])
                `SGT_SLOT_UPPER_LO: rd_w = upper_q[wch][7:0];
                `SGT_SLOT_UPPER_HI: rd_w = {4'h0, upper_q[wch][RW-1:8]};
                `SGT_SLOT_LOWER_LO: rd_w = lower_q[wch][7:0];
                default: rd_w = {4'h0, lower_q[wch][RW-1:8]};
            endcase
        end else begin
            case (reg_req_i.addr)
                `SGT_ADDR_ALARM0: rd_w = {3'h0, alarm_q[`SGT_N_ADC-1:0]};
                `SGT_ADDR_ALARM1: rd_w = {7'h00, alarm_q[NC-1]};
                `SGT_ADDR_STATUS: rd_w = status_w;
                `SGT_ADDR_PORT: rd_w = 8'(port_s);
                default: rd_w = `SGT_READ_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= '0;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_req_i.rd;
            if (reg_req_i.rd) begin
                reg_rdata_o <= rd_w;
            end
        end
    end

    // ------------------------------------------------------------------
    // assertions and covers
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    a_status_reset: assert property ($rose(rst_b_i) |-> status_w == `SGT_RST_STATUS)
        else $error("status not at reset value after reset");
    a_range_follow: assert property ((rst_b_i && $past(rst_b_i) && $past(rst_b_i, 2))
        |-> status_w.range == $past(range_det_i, 2))
        else $error("range flags do not follow detectors");
    a_auto_start: assert property (state_q == SGT_IDLE && conv_ctl_i.start && conv_ctl_i.auto_mode
        |=> !status_w.idle ##0 state_q == SGT_AUTO)
        else $error("idle did not drop on auto trigger");
    a_auto_hold: assert property (state_q == SGT_AUTO && !conv_ctl_i.stop |=> !status_w.idle)
        else $error("idle returned without stop");
    a_direct_done: assert property (state_q == SGT_DIRECT && conv_ctl_i.direct_done
        && !conv_ctl_i.auto_mode |=> status_w.idle && status_w.data_available_flag)
        else $error("direct completion not reported");
    a_global_alarm_set: assert property ((|alarm_q) |=> global_alarm_q)
        else $error("global alarm missed an alarm flag");
    a_global_alarm_sticky: assert property (global_alarm_q && !rd_status |=> global_alarm_q)
        else $error("global alarm cleared without status read");
    a_global_alarm_clear: assert property (rd_status && !(|alarm_q) |=> !global_alarm_q)
        else $error("global alarm not cleared by read");
    a_data_available_flag_auto: assert property (conv_ctl_i.auto_mode |=> !data_available_flag_q)
        else $error("data available set in auto mode");
    a_port_drive: assert property (reg_req_i.wr && reg_req_i.addr == `SGT_ADDR_PORT
        |=> port_pin_oe_o == ~$past(reg_req_i.wdata[PORT_W-1:0]) && port_pin_o == '0)
        else $error("port drive does not match written value");
    a_port_read: assert property (reg_req_i.rd && reg_req_i.addr == `SGT_ADDR_PORT
        |=> reg_rvalid_o && reg_rdata_o[PORT_W-1:0] == $past(port_s))
        else $error("port read is not the pin level");
    a_bound_order: assert property (upper_q[0] <= lower_q[0] |=> alarm_q[0])
        else $error("unordered bounds did not alarm");
    a_temp_window: assert property ($signed(res_q[NC-1]) > $signed(upper_q[NC-1])
        |=> alarm_q[NC-1])
        else $error("temperature above bound not flagged");

    c_direct_run: cover property (state_q == SGT_DIRECT ##[1:20] data_available_flag_q);
    c_auto_run: cover property (state_q == SGT_AUTO ##[1:20] state_q == SGT_IDLE);
    c_global_alarm_read: cover property (global_alarm_q && rd_status ##1 !global_alarm_q);
    c_port_low: cover property (|port_pin_oe_o);

endmodule

/* bench/sgt_pin_model.sv */
// open-drain pin environment: pull-ups and external devices on the port wires
`timescale 1ns/1ps
module sgt_pin_model (
    // device side of each pin
    input wire logic [7:0] pin_drive_i,
    input wire logic [7:0] pin_oe_i,
    // external devices sinking the wire, and the resolved level
    input wire logic [7:0] ext_low_i,
    output logic [7:0] pin_level_o
);
    // wired-and: whoever sinks wins, a released wire rises to the pull-up, never left floating
    assign pin_level_o = ~ext_low_i & (~pin_oe_i | pin_drive_i);
endmodule

/* bench/sgt_regs_tb.sv */
// self-checking bench for the status, port and threshold register bank
`timescale 1ns/1ps
module sgt_regs_tb
    import sgt_pkg::*;
;
    // ----------------------------------------------------------------
    // stimulus, clock and design
    // ----------------------------------------------------------------
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    sgt_reg_req_t rq = '0;
    sgt_conv_ctl_t cc = '0;
    sgt_results_t res = '0;
    logic [3:0] range_det = 4'h0;
    logic [7:0] ext_low = 8'h00;
    logic [7:0] rdata, pin_o, pin_oe, pin_lvl, v;
    logic rvalid;
    logic [31:0] seed = 32'h65a9;
    int bad_count = 0;
    int n_checks = 0;

    // free-running device clock, 100 ns period
    always #50 clk_i = ~clk_i;

    sgt_regs u_sgt_regs (.clk_i(clk_i), .rst_b_i(rst_b_i), .reg_req_i(rq), .reg_rdata_o(rdata),
        .reg_rvalid_o(rvalid), .conv_ctl_i(cc), .results_i(res), .range_det_i(range_det),
        .port_pin_i(pin_lvl), .port_pin_o(pin_o), .port_pin_oe_o(pin_oe));
    sgt_pin_model u_sgt_pin_model (.pin_drive_i(pin_o), .pin_oe_i(pin_oe), .ext_low_i(ext_low),
        .pin_level_o(pin_lvl));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // expected status byte; range flags follow the detectors live
    function automatic logic [7:0] st(input logic idle, input logic global_alarm, input logic data_available_flag);
        return {range_det, idle, 1'b1, global_alarm, data_available_flag};
    endfunction

    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        n_checks++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // inputs move 10 ns after the edge so sampling never races
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #10;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        tick(1);
        rq.addr = a;
        rq.wdata = d;
        rq.wr = 1'b1;
        tick(1);
        rq.wr = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
        tick(1);
        rq.addr = a;
        rq.rd = 1'b1;
        tick(1);
        rq.rd = 1'b0;
        chk("rvalid", 1'b1, rvalid);
        chk(nm, e, rdata);
    endtask

    // one-cycle converter strobe: bit 2 start, bit 1 stop, bit 0 done
    task automatic pulse(input logic [2:0] m);
        tick(1);
        cc[2:0] = m;
        tick(1);
        cc[2:0] = 3'b000;
    endtask

    // program one channel window, deliver a result, check flag and sticky global alarm
    task automatic win(input int s, input logic [11:0] u, input logic [11:0] l, input logic [11:0] r);
        logic [7:0] b;
        logic [7:0] ar;
        logic a;
        b = 8'h80 + 8'(4 * s);
        ar = (s == 5) ? 8'h71 : 8'h70;
        a = (s == 5) ? (($signed(u) <= $signed(l)) || ($signed(r) > $signed(u)) || ($signed(r) < $signed(l)))
            : ((u <= l) || (r > u) || (r < l));
        // result first: from a full window, narrowing low byte then high byte never alarms on the way
        tick(1);
        res.data[s] = r;
        res.valid[s] = 1'b1;
        tick(1);
        res.valid[s] = 1'b0;
        wr(b, u[7:0]);
        wr(b + 8'h1, {4'h0, u[11:8]});
        wr(b + 8'h2, l[7:0]);
        wr(b + 8'h3, {4'h0, l[11:8]});
        tick(2);
        rd(ar, (s == 5) ? {7'h00, a} : (8'(a) << s), "channel flag");
        rd(8'h72, st(1'b1, a, 1'b0), "global alarm");
        // widen lower first, then upper, so an inside result never sees a narrower window
        wr(b + 8'h2, 8'h00);
        wr(b + 8'h3, (s == 5) ? 8'h08 : 8'h00);
        wr(b, 8'hff);
        wr(b + 8'h1, (s == 5) ? 8'h07 : 8'h0f);
        tick(2);
        rd(ar, 8'h00, "flag cleared");
        rd(8'h72, st(1'b1, a, 1'b0), "sticky alarm");
        rd(8'h72, st(1'b1, 1'b0, 1'b0), "alarm read clear");
    endtask

    task automatic close_out();
        $display("counts: %0d checks, %0d bad", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // watchdog: a hung run is counted as a mismatch
    initial begin
        repeat (100000) @(posedge clk_i);
        bad_count++;
        $display("BAD watchdog expected done seen timeout");
        close_out();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clk_i);
        #10;
        rst_b_i = 1'b1;
        chk("oe after reset", 8'h00, pin_oe);
        rd(8'h72, 8'h0c, "status reset");
        rd(8'h7a, 8'hff, "port reset");
        rd(8'h80, 8'hff, "upper low reset");
        rd(8'h81, 8'h0f, "upper high reset");
        rd(8'h7b, 8'h00, "unmapped");
        wr(8'h72, 8'h00);
        rd(8'h72, 8'h0c, "status read-only");
        $display("test reset done");
        // range detectors, random levels
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            range_det = seed[3:0];
            tick(3);
            rd(8'h72, st(1'b1, 1'b0, 1'b0), "range flags");
        end
        range_det = 4'h0;
        tick(3);
        $display("test range done");
        // open-drain port, two corners then random
        for (int i = 0; i < 10; i++) begin
            seed = lfsr(seed);
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed[7:0];
            ext_low = (i == 0) ? 8'h00 : (i == 1) ? 8'ha5 : seed[15:8];
            wr(8'h7a, v);
            tick(1);
            chk("port oe", 8'(~v), pin_oe);
            chk("port drive", 8'h00, pin_o);
            tick(3);
            rd(8'h7a, v & ~ext_low, "port pins");
        end
        ext_low = 8'h00;
        $display("test port done");
        // window corners, then random windows on randomly chosen slots
        win(0, 12'h100, 12'h010, 12'h100);
        win(1, 12'h100, 12'h010, 12'h101);
        win(2, 12'h100, 12'h010, 12'h00f);
        win(4, 12'h200, 12'h200, 12'h200);
        win(5, 12'h050, 12'hff0, 12'hfe0);
        win(5, 12'h050, 12'hff0, 12'h000);
        for (int i = 0; i < 12; i++) begin
            seed = lfsr(seed);
            win(int'(seed[31:16]) % 6, seed[11:0], 12'(lfsr(seed) >> 20), seed[27:16]);
        end
        $display("test window done");
        // converter idle and data-available behaviour
        cc.auto_mode = 1'b1;
        pulse(3'b100);
        rd(8'h72, st(1'b0, 1'b0, 1'b0), "auto running");
        pulse(3'b010);
        rd(8'h72, st(1'b1, 1'b0, 1'b0), "auto stopped");
        cc.auto_mode = 1'b0;
        pulse(3'b100);
        rd(8'h72, st(1'b0, 1'b0, 1'b0), "direct running");
        pulse(3'b001);
        rd(8'h72, st(1'b1, 1'b0, 1'b1), "direct done");
        pulse(3'b100);
        rd(8'h72, st(1'b0, 1'b0, 1'b0), "direct restart");
        pulse(3'b001);
        cc.auto_mode = 1'b1;
        tick(2);
        rd(8'h72, st(1'b1, 1'b0, 1'b0), "auto hides data");
        $display("test converter done");
        close_out();
    end
endmodule
